// File: inc/temp_corr_params.svh
// Constants for the temperature offset correction block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef TEMP_CORR_PARAMS_SVH
`define TEMP_CORR_PARAMS_SVH
`define TC_LOCAL_IDX      8'h0d
`define TC_REMOTE_IDX     8'h0e
`define TC_READ_LOCAL     8'h10
`define TC_READ_REMOTE    8'h11
`define TC_CORR_RESET     8'h00
`define TC_SIGN_BIT       7
`define TC_RSV_HI         6
`define TC_RSV_LO         4
`define TC_MAG_HI         3
`define TC_MAG_LO         0
`define TC_TEMP_MAX       8'h7f
`define TC_TEMP_MIN       8'h80
`define TC_RD_MASK        8'h8f
`endif

// File: inc/temp_corr_pkg.sv
// Types shared by the offset correction files.
// Assumes the params header is on the include path.
`include "temp_corr_params.svh"
package temp_corr_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic {BUS_IDLE, BUS_DATA} bus_state_e;
endpackage : temp_corr_pkg

// File: inc/temp_corr_if.sv
// Carrier between the register file and the offset adder.
// Assumes one clock domain.
`timescale 1ns/1ps
interface temp_corr_if;
    logic [7:0] corr;
    logic [7:0] raw;
    logic [7:0] result;
    modport regs  (output corr, output raw, input result);
    modport adder (input corr, input raw, output result);
endinterface : temp_corr_if

// File: rtl/temp_offset_adder.sv
// Applies a sign-magnitude offset to a two's complement reading.
// Assumes a combinational consumer; result saturates at the 8-bit range.
`timescale 1ns/1ps
`include "temp_corr_params.svh"
module temp_offset_adder (
    temp_corr_if.adder cif
);
    wire       sign_w = cif.corr[`TC_SIGN_BIT];
    wire [8:0] raw_w  = {cif.raw[7], cif.raw};
    wire [8:0] mag_w  = {5'h00, cif.corr[`TC_MAG_HI:`TC_MAG_LO]};
    wire [8:0] sum_w  = sign_w ? (raw_w - mag_w) : (raw_w + mag_w);
    // Saturation avoids a hot reading wrapping round to a cold one.
    wire       ovf_w  = (sum_w[8] != sum_w[7]);
    assign cif.result = ovf_w ? (sum_w[8] ? `TC_TEMP_MIN : `TC_TEMP_MAX) : sum_w[7:0];
endmodule : temp_offset_adder

// File: rtl/temp_offset_correction.sv
// Offset correction registers with AHB-Lite slave and corrected readings.
// Assumes single-word AHB-Lite transfers; raw readings come from the ADC.
//
// Behaviour
// - Local sign zero adds local offset.
// - Local sign one subtracts local offset.
// - Local bits three to zero hold magnitude.
// - Remote sign zero adds remote offset.
// - Remote sign one subtracts remote offset.
// - Remote bits three to zero hold magnitude.
// - Bits six to four store, read zero.
// - Both offset registers reset to zero.
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "temp_corr_params.svh"
module temp_offset_correction (
    // Clock and reset.
    input  wire logic        REF_CLK_I,
    input  wire logic        RST_N_I,
    // AHB-Lite slave.
    input  wire logic        HSEL_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    output logic      [31:0] HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    // Raw readings and corrected results.
    input  wire logic [7:0]  LOCAL_RAW_I,
    input  wire logic [7:0]  REMOTE_RAW_I,
    output logic      [7:0]  LOCAL_TEMP_O,
    output logic      [7:0]  REMOTE_TEMP_O
);
    ////////////////////////////////////////////////////////////////////////////
    temp_corr_pkg::byte_t      local_q;
    temp_corr_pkg::byte_t      remote_q;
    temp_corr_pkg::bus_state_e state_q;
    logic                      wr_q;
    logic [7:0]                idx_q;
    logic [31:0]               rdata_q;
    logic                      ready_q;
    logic                      resp_q;

    temp_corr_if loc_if ();
    temp_corr_if rem_if ();
    assign loc_if.corr = local_q;
    assign loc_if.raw  = LOCAL_RAW_I;
    assign rem_if.corr = remote_q;
    assign rem_if.raw  = REMOTE_RAW_I;

    temp_offset_adder u_local (
        .cif (loc_if)
    );
    temp_offset_adder u_remote (
        .cif (rem_if)
    );

    ////////////////////////////////////////////////////////////////////////////
    wire       start_w  = HSEL_I & HREADY_I & HTRANS_I[1];
    wire [7:0] aidx_w   = HADDR_I[9:2];
    wire       wr_loc_w = (state_q == temp_corr_pkg::BUS_DATA) & wr_q
                          & (idx_q == `TC_LOCAL_IDX);
    wire       wr_rem_w = (state_q == temp_corr_pkg::BUS_DATA) & wr_q
                          & (idx_q == `TC_REMOTE_IDX);
    wire [7:0] rd_mask_w = `TC_RD_MASK;
    wire [7:0] rsel_w =
        (aidx_w == `TC_LOCAL_IDX)   ? (local_q & rd_mask_w)  :
        (aidx_w == `TC_REMOTE_IDX)  ? (remote_q & rd_mask_w) :
        (aidx_w == `TC_READ_LOCAL)  ? loc_if.result          :
        (aidx_w == `TC_READ_REMOTE) ? rem_if.result          : `TC_CORR_RESET;

    // The slave answers with zero wait states, so the data phase is one cycle.
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_q <= temp_corr_pkg::BUS_IDLE;
            wr_q    <= 1'b0;
            idx_q   <= 8'h00;
            rdata_q <= 32'h0000_0000;
            ready_q <= 1'b1;
            resp_q  <= 1'b0;
        end else begin
            ready_q <= 1'b1;
            resp_q  <= 1'b0;
            state_q <= start_w ? temp_corr_pkg::BUS_DATA : temp_corr_pkg::BUS_IDLE;
            wr_q    <= start_w & HWRITE_I;
            idx_q   <= aidx_w;
            rdata_q <= (start_w & ~HWRITE_I) ? {24'h00_0000, rsel_w} : 32'h0000_0000;
        end
    end

    // reset clears offsets; store whole byte.
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            local_q  <= `TC_CORR_RESET;
            remote_q <= `TC_CORR_RESET;
        end else begin
            if (wr_loc_w) begin
                local_q <= HWDATA_I[7:0];
            end
            if (wr_rem_w) begin
                remote_q <= HWDATA_I[7:0];
            end
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            LOCAL_TEMP_O  <= 8'h00;
            REMOTE_TEMP_O <= 8'h00;
        end else begin
            LOCAL_TEMP_O  <= loc_if.result;
            REMOTE_TEMP_O <= rem_if.result;
        end
    end

    assign HRDATA_O    = rdata_q;
    assign HREADYOUT_O = ready_q;
    assign HRESP_O     = resp_q;
endmodule : temp_offset_correction

// File: bench/temp_offset_correction_monitor.sv
// Port checks for the offset block.
// Assumes one slave whose HREADYOUT_O is the bus hready.
`timescale 1ns/1ps
module temp_offset_correction_monitor (
    input wire logic        REF_CLK_I, RST_N_I, HSEL_I, HWRITE_I, HREADYOUT_O, HRESP_O,
    input wire logic [1:0]  HTRANS_I,
    input wire logic [31:0] HADDR_I, HWDATA_I, HRDATA_O,
    input wire logic [7:0]  LOCAL_TEMP_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);
    sequence s_req(w); HSEL_I && HTRANS_I[1] && HWRITE_I == w; endsequence
    sequence s_wr; s_req(1'b1) ##0 HADDR_I[9:2] inside {8'h0d, 8'h0e}; endsequence
    a_ready_high: assert property (HREADYOUT_O) else $error("Ready low.");
    a_resp_okay: assert property (!HRESP_O) else $error("Error response.");
    a_upper_zero: assert property (HRDATA_O[31:8] == 24'h0) else $error("Upper bits set.");
    a_rsv_zero: assert property (s_req(1'b0) ##0 HADDR_I[9:2] inside {8'h0d, 8'h0e} |=>
        HRDATA_O[6:4] == 3'h0) else $error("Spare bits set.");
    a_idle_zero: assert property (!(HSEL_I && HTRANS_I[1]) |=> HRDATA_O == 32'h0)
        else $error("Data outside data phase.");
    a_unmapped_zero: assert property (s_req(1'b0) ##0 HADDR_I[9:2] == 8'h20 |=> HRDATA_O == 0)
        else $error("Unmapped read not zero.");
    a_write_back: assert property (s_wr ##2 s_req(1'b0) ##0 HADDR_I == $past(HADDR_I, 2) |=>
        HRDATA_O[7:0] == ($past(HWDATA_I[7:0], 2) & 8'h8f)) else $error("Readback wrong.");
    a_reset_clear: assert property ($rose(RST_N_I) |-> LOCAL_TEMP_O == 8'h0)
        else $error("Reading not cleared.");
endmodule : temp_offset_correction_monitor
bind temp_offset_correction temp_offset_correction_monitor i_mon (.*);

// File: bench/test_temp_offset_correction.sv
// Self-checking bench: AHB-Lite register traffic and random raw readings.
// Assumes zero wait states are not taken for granted; hready is waited on.
`timescale 1ns/1ps
module test_temp_offset_correction;
    logic        REF_CLK_I = 0, RST_N_I = 0, HSEL_I = 0, HWRITE_I = 0;
    logic [1:0]  HTRANS_I = 0;
    logic [2:0]  HSIZE_I = 3'h2;
    logic [31:0] HADDR_I = 0, HWDATA_I = 0, seed = 32'h35;
    logic [7:0]  LOCAL_RAW_I = 0, REMOTE_RAW_I = 0, rd, lo, re;
    wire  [31:0] HRDATA_O;
    wire         HREADYOUT_O, HRESP_O;
    wire  [7:0]  LOCAL_TEMP_O, REMOTE_TEMP_O;
    int          errors = 0, checks_done = 0;
    temp_offset_correction i_temp_offset_correction (.HREADY_I(HREADYOUT_O), .*);
    always #2.5 REF_CLK_I = ~REF_CLK_I;
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    // Saturation keeps a hot reading from wrapping to a cold one.
    function automatic logic [7:0] exp_f(logic [7:0] raw, off);
        int s = $signed(raw) + (off[7] ? -int'(off[3:0]) : int'(off[3:0]));
        return s > 127 ? 8'h7f : s < -128 ? 8'h80 : s[7:0];
    endfunction : exp_f
    task chk(input logic [7:0] g, e);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, g, e);
        end
    endtask : chk
    task bus(input logic w, input logic [7:0] ix, wd);
        HSEL_I <= 1;
        HTRANS_I <= 2'h2;
        HWRITE_I <= w;
        HADDR_I <= {22'h0, ix, 2'h0};
        do @(posedge REF_CLK_I); while (HREADYOUT_O !== 1'b1);
        HSEL_I <= 0;
        HTRANS_I <= 0;
        HWDATA_I <= {24'h0, wd};
        do @(posedge REF_CLK_I); while (HREADYOUT_O !== 1'b1);
        rd = HRDATA_O[7:0];
    endtask : bus
    task end_sim;
        $display("errors %0d, checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim
    initial begin
        #20000;
        errors++;
        end_sim();
    end
    initial begin
        repeat (4) @(posedge REF_CLK_I);
        RST_N_I <= 1;
        @(posedge REF_CLK_I);
        bus(0, 8'h0d, 0); chk(rd, 0);
        bus(0, 8'h0e, 0); chk(rd, 0);
        bus(1, 8'h20, 8'hff); bus(0, 8'h20, 0); chk(rd, 0);
        for (int i = 0; i < 40; i++) begin
            lo = i == 0 ? 8'h0f : i == 1 ? 8'h00 : rnd();
            re = i == 0 ? 8'h8f : i == 1 ? 8'h00 : rnd();
            LOCAL_RAW_I <= i == 0 ? 8'h7f : rnd();
            REMOTE_RAW_I <= i == 0 ? 8'h80 : rnd();
            bus(1, 8'h0d, lo); bus(0, 8'h0d, 0); chk(rd, lo & 8'h8f);
            bus(1, 8'h0e, re); bus(0, 8'h0e, 0); chk(rd, re & 8'h8f);
            bus(0, 8'h10, 0); chk(rd, exp_f(LOCAL_RAW_I, lo));
            bus(0, 8'h11, 0); chk(rd, exp_f(REMOTE_RAW_I, re));
            chk(LOCAL_TEMP_O, exp_f(LOCAL_RAW_I, lo));
            chk(REMOTE_TEMP_O, exp_f(REMOTE_RAW_I, re));
        end
        RST_N_I <= 0;
        repeat (2) @(posedge REF_CLK_I);
        RST_N_I <= 1;
        @(posedge REF_CLK_I);
        bus(0, 8'h0d, 0); chk(rd, 0);
        bus(0, 8'h0e, 0); chk(rd, 0);
        end_sim();
    end
endmodule : test_temp_offset_correction
